// ---- rtl/bct_pkg.sv ----
// Package with constants and carrier types for the battery conditioning timer.
package bct_pkg;

  // Mains-derived counting clock and the cascade layout.
  localparam int LINE_HZ = 60;
  localparam int PRESCALE_BITS = 12;
  localparam int UPPER_BITS = 4;
  localparam int PRESCALE_DIV = 4096;
  localparam int COUNT_BITS = PRESCALE_BITS + UPPER_BITS;

  // Terminal count in line cycles after a clear.
  localparam logic [15:0] TERMINAL_COUNT = 16'h8922;

  // Interval that the terminal count stands for, in seconds.
  localparam int INTERVAL_S = (int'(TERMINAL_COUNT) + LINE_HZ - 1) / LINE_HZ;

  // Reset value of the control flip-flop: set, relay coil released.
  localparam logic RELAY_CTRL_RST = 1'b1;

  // Cascaded count as one carrier: upper counter above the prescale counter.
  typedef struct packed {
    logic [UPPER_BITS-1:0] upper_counter;
    logic [PRESCALE_BITS-1:0] prescale_counter;
  } bct_count_t;

endpackage

// ---- rtl/bct_battery_conditioning_timer.sv ----
// Battery conditioning timer: line-cycle counter cascade, decoder and relay control.
// Function
// - Count one step per mains line cycle.
// - Prescaler carries into upper counter every 4096.
// - Five-input decoder detects terminal count bits.
// - At count 35106 decoder switches relay off.
// - Pushbutton low clears flip-flop and both counters.
// - Cleared flip-flop energizes relay coil driver.
// - Terminal count sets flip-flop, coil released.
// - Power-on reset leaves relay deenergized.
`timescale 1ns/10ps
module bct_battery_conditioning_timer #(
  parameter int PRESCALE_BITS = bct_pkg::PRESCALE_BITS,
  parameter int UPPER_BITS = bct_pkg::UPPER_BITS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Mains-derived line clock, clamped to logic levels
  input wire logic line_clk_in,
  // Momentary start pushbutton, low while pressed
  input wire logic start_pushbutton_n,
  // Relay side
  output logic coil_drive,
  output logic terminal_count,
  output bct_pkg::bct_count_t count
);

  // The carrier struct fixes the split of the count, so other widths are refused.
  if (PRESCALE_BITS != bct_pkg::PRESCALE_BITS ||
      UPPER_BITS != bct_pkg::UPPER_BITS) begin : g_bad_width
    $error("Cascade widths must match the carrier layout.");
  end
  // The carry into the upper counter must fall every PRESCALE_DIV line cycles.
  if ((1 << PRESCALE_BITS) != bct_pkg::PRESCALE_DIV) begin : g_bad_div
    $error("Prescale width does not give the carry period.");
  end

  // The decoder looks only at the bits that are one in the terminal count.
  // As in a gate decoder, the first count that shows all of them is exactly the
  // terminal count, so no full comparator is needed.
  function automatic logic decode_terminal(input bct_pkg::bct_count_t c);
    logic [bct_pkg::COUNT_BITS-1:0] flat;
    flat = c;
    decode_terminal = ((flat & bct_pkg::TERMINAL_COUNT) == bct_pkg::TERMINAL_COUNT);
  endfunction

  logic line_prev_r;
  logic line_rise;
  logic decode_prev_r;
  logic tc_rise;
  logic relay_ctrl_r;
  logic prescale_wrap;
  bct_pkg::bct_count_t count_r;

  // Line clock is a slow synchronous level; its rising edge is one count.
  // The previous sample follows the pin even in reset, so a line that is high
  // when reset ends is not taken for a fresh edge.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      line_prev_r <= line_clk_in;
    end else begin
      line_prev_r <= line_clk_in;
    end
  end

  assign line_rise = line_clk_in & ~line_prev_r;
  assign prescale_wrap = &count_r.prescale_counter;

  // Counter cascade; the pushbutton holds both counters cleared. After the
  // interval it runs on and wraps, which is harmless because the relay is already
  // released and later decoder edges only set the flip-flop again.
  always_ff @(posedge ref_clk) begin
    if (reset || !start_pushbutton_n) begin
      count_r <= '0;
    end else if (line_rise) begin
      count_r.prescale_counter <= count_r.prescale_counter + 1'b1;
      if (prescale_wrap) begin
        count_r.upper_counter <= count_r.upper_counter + 1'b1;
      end
    end
  end

  assign terminal_count = decode_terminal(count_r);

  // The decoder output clocks the flip-flop, so only its rising edge acts.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      decode_prev_r <= 1'b0;
    end else begin
      decode_prev_r <= terminal_count;
    end
  end

  // A press that meets this edge wins in the flip-flop below; the edge is then
  // lost on purpose, since the press restarts the interval from zero.
  assign tc_rise = terminal_count & ~decode_prev_r;

  // Control flip-flop. The pushbutton clear wins over the decoder clock, the way
  // a direct reset overrides a clock edge. Once set, later decoder edges only set
  // it again, so the relay stays released until the next press.
  // The relay drops one clock after the decoder first rises; line edges are at
  // least two clocks apart, so the count still shows the terminal value then.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      relay_ctrl_r <= bct_pkg::RELAY_CTRL_RST;
    end else if (!start_pushbutton_n) begin
      relay_ctrl_r <= 1'b0;
    end else if (tc_rise) begin
      relay_ctrl_r <= 1'b1;
    end
  end

  // Inverted flip-flop output drives the coil through the driver stage.
  assign coil_drive = ~relay_ctrl_r;
  assign count = count_r;

  // Checks are sampled on ref_clk and paused while the power-on reset is held, except AST_RESET_HOLD.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_LINE_STEP: assert property (
    (line_rise && start_pushbutton_n && !prescale_wrap) |=>
      (count_r.prescale_counter == $past(count_r.prescale_counter) + 1'b1)
  ) else $error("Prescale counter did not step on a line cycle.");

  AST_COUNT_HOLD: assert property (
    (!line_rise && start_pushbutton_n) |=> $stable(count_r)
  ) else $error("Count moved without a line cycle.");

  AST_PRESCALE_CARRY: assert property (
    (line_rise && start_pushbutton_n && prescale_wrap) |=>
      (count_r.upper_counter == $past(count_r.upper_counter) + 1'b1) &&
      (count_r.prescale_counter == '0)
  ) else $error("Upper counter did not advance on prescale carry.");

  // Later decoder edges, while the count runs on, come only with the relay off.
  AST_DECODE_EXACT: assert property (
    ($rose(terminal_count) && coil_drive) |-> (count_r == bct_pkg::TERMINAL_COUNT)
  ) else $error("Decoder fired away from the terminal count.");

  AST_TC_RELEASE: assert property (
    (tc_rise && start_pushbutton_n) |=> !coil_drive ##1
      (!coil_drive || !$past(start_pushbutton_n)) ##1
      (!coil_drive || !$past(start_pushbutton_n) || !$past(start_pushbutton_n, 2))
  ) else $error("Relay not released at terminal count.");

  AST_PRESS_CLEAR: assert property (
    !start_pushbutton_n |=> (count_r == '0) && coil_drive
  ) else $error("Press did not clear counters and energize relay.");

  AST_ENERGIZED_HOLD: assert property (
    (coil_drive && start_pushbutton_n && !tc_rise) |=> coil_drive
  ) else $error("Relay dropped before terminal count.");

  AST_STAY_OFF: assert property (
    (!coil_drive && start_pushbutton_n) |=> !coil_drive
  ) else $error("Relay reenergized without a press.");

  AST_POWER_ON: assert property (
    $fell(reset) |-> !coil_drive && (count_r == '0)
  ) else $error("Relay energized after power-on reset.");

  AST_ONE_INTERVAL: assert property (
    ($fell(coil_drive) && start_pushbutton_n && !$past(reset)) |-> $past(tc_rise)
  ) else $error("Relay released without a terminal count edge.");

  // Checks on the outputs and on the interval as a whole.
  AST_UPPER_HOLD: assert property (
    (start_pushbutton_n && !(line_rise && prescale_wrap)) |=>
      $stable(count_r.upper_counter)
  ) else $error("Upper counter moved without a prescale carry.");

  AST_COUNT_WRAP: assert property (
    ((count_r == '1) && line_rise && start_pushbutton_n) |=> (count_r == '0)
  ) else $error("Cascade did not wrap to zero.");

  AST_NO_EARLY_DECODE: assert property (
    (count_r < bct_pkg::TERMINAL_COUNT) |-> !terminal_count
  ) else $error("Decoder active below the terminal count.");

  AST_INTERVAL_END: assert property (
    ($fell(coil_drive) && !$past(reset)) |-> (count_r == bct_pkg::TERMINAL_COUNT)
  ) else $error("Relay released away from the terminal count.");

  AST_PRESS_WINS: assert property (
    (tc_rise && !start_pushbutton_n) |=> coil_drive && (count_r == '0)
  ) else $error("Terminal count edge overrode a press.");

  AST_PRESSED_IDLE: assert property (
    (!start_pushbutton_n && line_rise) |=> (count_r == '0)
  ) else $error("Line edge counted while the button was pressed.");

  AST_DECODE_CLEAR: assert property (
    !start_pushbutton_n |=> !terminal_count
  ) else $error("Decoder active after a press.");

  AST_RELEASE_ENERGIZED: assert property (
    ($rose(start_pushbutton_n) && !$past(reset)) |-> coil_drive && (count_r == '0)
  ) else $error("Relay not energized when the press ended.");

  AST_ENERGIZED_RANGE: assert property (
    coil_drive |-> (count_r <= bct_pkg::TERMINAL_COUNT)
  ) else $error("Relay energized beyond the terminal count.");

  AST_COIL_OFF_NEXT: assert property (
    ($rose(terminal_count) && coil_drive && start_pushbutton_n) |=> !coil_drive
  ) else $error("Relay not released after the decoder rose.");

  AST_RESET_HOLD: assert property (
    disable iff (1'b0)
    reset |=> !coil_drive && (count_r == '0) && !terminal_count
  ) else $error("Relay or count not held off during reset.");

  COV_START: cover property (!start_pushbutton_n ##1 start_pushbutton_n && coil_drive);
  COV_CARRY: cover property (line_rise && prescale_wrap && start_pushbutton_n);
  COV_INTERVAL_END: cover property (coil_drive ##1 !coil_drive);
  COV_RESTART: cover property (!coil_drive ##1 !start_pushbutton_n ##1 coil_drive);
  COV_DECODE: cover property ($rose(terminal_count) && coil_drive);

endmodule

// ---- verification/bct_line_model.sv ----
// Partner model: mains-derived line clock feeding the timer.
`timescale 1ns/10ps
module bct_line_model (
  // Clock
  input wire logic ref_clk,
  // Bench control
  input wire logic run,
  // Line clock to the timer
  output logic line_clk_in
);
  initial line_clk_in = 1'b0;
  // Toggling every cycle leaves one low cycle between rises, the tightest legal spacing.
  always @(negedge ref_clk) begin
    line_clk_in <= run ? ~line_clk_in : 1'b0;
  end
endmodule

// ---- verification/tb.sv ----
// Self-checking testbench for the battery conditioning timer.
`timescale 1ns/10ps
module tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic run = 1'b0;
  logic start_pushbutton_n = 1'b1;
  logic line_clk_in;
  logic coil_drive;
  logic terminal_count;
  bct_pkg::bct_count_t count;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2 ref_clk = ~ref_clk;
  bct_line_model u_line (.ref_clk(ref_clk), .run(run), .line_clk_in(line_clk_in));
  bct_battery_conditioning_timer u_dut (.ref_clk(ref_clk), .reset(reset),
    .line_clk_in(line_clk_in), .start_pushbutton_n(start_pushbutton_n),
    .coil_drive(coil_drive), .terminal_count(terminal_count), .count(count));
  task automatic close_out();
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Outputs are looked at on falling edges, where they have settled.
  task automatic wait_count(logic [15:0] v);
    int n;
    n = 0;
    while (count !== v && n < 80000) begin
      @(negedge ref_clk);
      n++;
    end
    chk("count reached", v, count);
  endtask
  task automatic press(int hold);
    @(negedge ref_clk);
    start_pushbutton_n = 1'b0;
    repeat (hold) @(negedge ref_clk);
    chk("count held", 16'h0000, count);
    chk("coil on", 16'h0001, {15'h0000, coil_drive});
    start_pushbutton_n = 1'b1;
  endtask
  task automatic t_power_on();
    repeat (3) @(negedge ref_clk);
    chk("coil at reset", 16'h0000, {15'h0000, coil_drive});
    reset = 1'b0;
    run = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk("coil idle", 16'h0000, {15'h0000, coil_drive});
  endtask
  task automatic t_interval();
    press(6);
    wait_count(16'(bct_pkg::PRESCALE_DIV - 1));
    @(negedge ref_clk);
    @(negedge ref_clk);
    chk("carry", 16'(bct_pkg::PRESCALE_DIV), count);
    wait_count(bct_pkg::TERMINAL_COUNT - 16'h0001);
    chk("early decode", 16'h0000, {15'h0000, terminal_count});
    chk("coil before end", 16'h0001, {15'h0000, coil_drive});
    wait_count(bct_pkg::TERMINAL_COUNT);
    chk("decode", 16'h0001, {15'h0000, terminal_count});
    @(negedge ref_clk);
    chk("coil off", 16'h0000, {15'h0000, coil_drive});
    wait_count(bct_pkg::TERMINAL_COUNT + 16'h001e);
    chk("coil stays off", 16'h0000, {15'h0000, coil_drive});
  endtask
  task automatic t_restart();
    press(1);
    wait_count(16'h0010);
    press(2);
  endtask
  task automatic t_midrun_reset();
    wait_count(16'h0008);
    reset = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("coil in reset", 16'h0000, {15'h0000, coil_drive});
    chk("count in reset", 16'h0000, count);
    reset = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("coil after reset", 16'h0000, {15'h0000, coil_drive});
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    t_power_on();
    t_interval();
    t_restart();
    t_midrun_reset();
    close_out();
  end
endmodule
